// ===== design/vector_fp_map.vh
// Purpose: Offsets, field positions and reset values of the vector
//          control register bank.
// Assumes: Registers selected by a 3-bit control index.
// Notes:   Definitions only.
`ifndef VECTOR_FP_MAP_VH
`define VECTOR_FP_MAP_VH

`define IDX_IMPL_INFO      3'h0
`define IDX_CTRL_STATUS    3'h1
`define IDX_AVAILABLE      3'h2
`define IDX_SAVED          3'h3
`define IDX_MODIFIED       3'h4
`define IDX_REQUESTED      3'h5
`define IDX_MAP            3'h6
`define IDX_UNMAP          3'h7

`define IMPL_PART_BIT      16
`define IMPL_CODE_HI       15
`define IMPL_CODE_LO       8
`define IMPL_REV_HI        7
`define IMPL_REV_LO        0

`define CS_FLUSH_BIT       24
`define CS_NONTRAP_BIT     18
`define CS_CAUSE_HI        17
`define CS_CAUSE_LO        12
`define CS_ENABLE_HI       11
`define CS_ENABLE_LO       7
`define CS_FLAG_HI         6
`define CS_FLAG_LO         2
`define CS_ROUND_HI        1
`define CS_ROUND_LO        0

// Cause order: unimpl, invalid, divzero, overflow, underflow, inexact
`define EXC_UNIMPL         5
`define EXC_OVERFLOW       2
`define EXC_INEXACT        0

`define FLUSH_RESET        1'h0
`define NONTRAP_RESET      1'h0
`define ROUND_RESET        2'h0
`define MASK_RESET         32'h00000000
`define INDEX_RESET        5'h00

`endif

// ===== design/vector_fp_exc_merge.v
// Purpose: Folds per-element exception conditions into one
//          instruction-level set and splits trapping from flagged ones.
// Assumes: Six condition bits per element, cause-field order.
// Notes:   Pure combinational.
`timescale 1ns/100ps
`default_nettype none
`include "vector_fp_map.vh"

module vector_fp_exc_merge (
  input  wire [23:0] elem_exc,
  input  wire [3:0]  elem_valid,
  input  wire [4:0]  enable_bits,
  output wire [5:0]  cause_set,
  output wire        trap_hit,
  output wire [4:0]  flag_set
);
  wire [5:0] part [0:3];
  wire [5:0] merged;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      // Overflow without its enable also reports inexact
      assign part[g] = elem_valid[g] ?
        (elem_exc[g*6 +: 6] |
         {5'h00, elem_exc[g*6+`EXC_OVERFLOW] & ~enable_bits[`EXC_OVERFLOW]})
        : 6'h00;
    end
  endgenerate

  // Any valid element sets the bit for the instruction
  assign merged    = part[0] | part[1] | part[2] | part[3];
  assign cause_set = merged;
  // Unimplemented has no enable and always traps
  assign trap_hit  = merged[`EXC_UNIMPL] |
                     (|(merged[4:0] & enable_bits));
  // Only conditions with enable off reach the flags
  assign flag_set  = merged[4:0] & ~enable_bits;
endmodule
`default_nettype wire

// ===== design/vector_fp_control_regs.v
// Purpose: Control register bank of the vector floating-point unit.
// Assumes: Copy instructions arrive as one-cycle strobes with an index.
// Notes:   Per-thread copies of the control/status and partition masks.
//
// Operation
// - Eight indices; 2..7 privileged or reserved
// - Implementation register read-only, shared by threads
// - Partition bit 16, code 15:8, revision
// - Control/status read-write, one per thread
// - Bits 31:25 read zero
// - Flush bit optional, resets to zero
// - Flush mode replaces subnormals, no unimplemented
// - Trapping mode: no write, cause, trap
// - Nontrap mode: signaling NaN, no trap
// - Cause recomputed per vector instruction in trapping mode; nontrap mode keeps it
// - Enabled cause bit raises exception
// - Unimplemented cause always traps; code does not trap on it in nontrap mode, where it substitutes a NaN
// - Flags only set for disabled conditions
// - Rounding field selects mode, resets zero
// - Invalid gives default quiet NaN
// - Divide-by-zero gives signed infinity
// - Overflow untrapped also sets inexact
// - Vector register usable only if mapped
`timescale 1ns/100ps
`default_nettype none
`include "vector_fp_map.vh"

module vector_fp_control_regs #(
  parameter       PARTITION_SUPPORT = 1'b1,
  parameter       FLUSH_PRESENT     = 1'b1,
  parameter [7:0] PROCESSOR_CODE    = 8'h5A, // Arbitrary value
  parameter [7:0] REVISION_CODE     = 8'h01  // Arbitrary value
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [1:0]  thread_sel,
  input  wire        privileged_mode,
  input  wire        copy_to_control_insn,
  input  wire        copy_from_control_insn,
  input  wire [2:0]  ctrl_index,
  input  wire [31:0] ctrl_wdata,
  input  wire        fp_insn_done,
  input  wire [3:0]  elem_valid,
  input  wire [23:0] elem_exc,
  input  wire [1:0]  fp_thread_sel,
  input  wire [31:0] modify_set,
  input  wire [31:0] request_bits,
  input  wire        request_load,
  input  wire [4:0]  vreg_check,
  output reg  [31:0] ctrl_rdata,
  output reg         ctrl_rvalid,
  output reg         reserved_insn,
  output reg         fp_exception,
  output reg         dest_write_en,
  output reg         nan_substitute,
  output reg  [5:0]  nan_payload,
  output reg         flush_subnormal,
  output reg         nontrap_mode,
  output reg  [1:0]  round_select,
  output reg         vreg_usable
);
  reg        rst_meta_reg;
  reg        rst_sync_reg;
  wire       rst_n;

  // Per-thread state
  reg        flush_reg    [0:3];
  reg        nontrap_reg  [0:3];
  reg  [5:0] cause_reg    [0:3];
  reg  [4:0] enable_reg   [0:3];
  reg  [4:0] flag_reg     [0:3];
  reg  [1:0] round_reg    [0:3];
  reg [31:0] avail_reg    [0:3];
  reg [31:0] saved_reg    [0:3];
  reg [31:0] modified_reg [0:3];
  reg [31:0] request_reg  [0:3];
  reg  [4:0] map_reg      [0:3];
  reg  [4:0] unmap_reg    [0:3];

  wire [31:0] impl_word;
  wire [31:0] cs_word;
  wire [5:0]  cause_set;
  wire        trap_hit;
  wire [4:0]  flag_set;
  wire        priv_idx;
  wire        idx_ok;
  wire        wr_go;
  wire        rd_go;
  wire [5:0]  wr_cause;
  wire [4:0]  wr_enable;
  wire        wr_trap;
  reg  [31:0] rd_word;

  // Release reset through two stages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Shared by all threads, never written
  assign impl_word = {15'h0000, PARTITION_SUPPORT[0],
                      PROCESSOR_CODE, REVISION_CODE};

  // Upper bits and unused gaps read zero
  assign cs_word = {7'h00, flush_reg[thread_sel], 5'h00,
                    nontrap_reg[thread_sel], cause_reg[thread_sel],
                    enable_reg[thread_sel], flag_reg[thread_sel],
                    round_reg[thread_sel]};

  // Indices 2..7: privileged, or reserved without partitioning
  assign priv_idx = (ctrl_index != `IDX_IMPL_INFO) &&
                    (ctrl_index != `IDX_CTRL_STATUS);
  assign idx_ok   = !priv_idx ||
                    (PARTITION_SUPPORT[0] && privileged_mode);
  assign wr_go    = copy_to_control_insn && idx_ok;
  assign rd_go    = copy_from_control_insn && idx_ok;

  // Software write of cause with enable set traps at once
  assign wr_cause  = ctrl_wdata[`CS_CAUSE_HI:`CS_CAUSE_LO];
  assign wr_enable = ctrl_wdata[`CS_ENABLE_HI:`CS_ENABLE_LO];
  assign wr_trap   = wr_go && (ctrl_index == `IDX_CTRL_STATUS) &&
                     (wr_cause[`EXC_UNIMPL] |
                      (|(wr_cause[4:0] & wr_enable)));

  vector_fp_exc_merge u_merge (
    .elem_exc    (elem_exc),
    .elem_valid  (elem_valid),
    .enable_bits (enable_reg[fp_thread_sel]),
    .cause_set   (cause_set),
    .trap_hit    (trap_hit),
    .flag_set    (flag_set)
  );

  always @* begin
    case (ctrl_index)
      `IDX_IMPL_INFO:   rd_word = impl_word;
      `IDX_CTRL_STATUS: rd_word = cs_word;
      `IDX_AVAILABLE:   rd_word = avail_reg[thread_sel];
      `IDX_SAVED:       rd_word = saved_reg[thread_sel];
      `IDX_MODIFIED:    rd_word = modified_reg[thread_sel];
      `IDX_REQUESTED:   rd_word = request_reg[thread_sel];
      `IDX_MAP:         rd_word = {27'h0000000, map_reg[thread_sel]};
      `IDX_UNMAP:       rd_word = {27'h0000000, unmap_reg[thread_sel]};
      default:          rd_word = 32'h00000000;
    endcase
  end

  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1) begin : thr
      wire cs_wr  = wr_go && (thread_sel == t) &&
                    (ctrl_index == `IDX_CTRL_STATUS);
      wire fp_hit = fp_insn_done && (fp_thread_sel == t);
      wire sw_wr  = wr_go && (thread_sel == t);

      // Cause/enable/flag have no reset value; left unreset
      always @(posedge clk) begin
        if (cs_wr) begin
          cause_reg[t]  <= wr_cause;
          enable_reg[t] <= wr_enable;
        end else if (fp_hit && !nontrap_reg[t]) begin
          cause_reg[t]  <= cause_set;
        end
        // Nontrap mode leaves cause untouched
        // Hardware set wins over a software clear
        if (fp_hit && !(trap_hit && !nontrap_reg[t])) begin
          flag_reg[t] <= (cs_wr ?
            ctrl_wdata[`CS_FLAG_HI:`CS_FLAG_LO] : flag_reg[t]) | flag_set;
        end else if (cs_wr) begin
          flag_reg[t] <= ctrl_wdata[`CS_FLAG_HI:`CS_FLAG_LO];
        end
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flush_reg[t]    <= `FLUSH_RESET;
          nontrap_reg[t]  <= `NONTRAP_RESET;
          round_reg[t]    <= `ROUND_RESET;
          avail_reg[t]    <= `MASK_RESET;
          saved_reg[t]    <= `MASK_RESET;
          modified_reg[t] <= `MASK_RESET;
          request_reg[t]  <= `MASK_RESET;
          map_reg[t]      <= `INDEX_RESET;
          unmap_reg[t]    <= `INDEX_RESET;
        end else begin
          if (cs_wr) begin
            // Flush bit ignored when absent
            flush_reg[t]   <= FLUSH_PRESENT[0] &
                              ctrl_wdata[`CS_FLUSH_BIT];
            nontrap_reg[t] <= ctrl_wdata[`CS_NONTRAP_BIT];
            round_reg[t]   <= ctrl_wdata[`CS_ROUND_HI:`CS_ROUND_LO];
          end
          if (sw_wr && ctrl_index == `IDX_SAVED)
            saved_reg[t] <= ctrl_wdata;
          // Hardware OR update wins over a software clear
          if (sw_wr && ctrl_index == `IDX_MODIFIED)
            modified_reg[t] <= ctrl_wdata | (fp_hit ? modify_set : 32'h0);
          else if (fp_hit)
            modified_reg[t] <= modified_reg[t] | modify_set;
          // Request cleared then loaded per instruction
          if (request_load && fp_thread_sel == t)
            request_reg[t] <= request_bits;
          // Map sets, unmap clears an availability bit
          if (sw_wr && ctrl_index == `IDX_MAP) begin
            map_reg[t] <= ctrl_wdata[4:0];
            avail_reg[t][ctrl_wdata[4:0]] <= 1'b1;
          end
          if (sw_wr && ctrl_index == `IDX_UNMAP) begin
            unmap_reg[t] <= ctrl_wdata[4:0];
            avail_reg[t][ctrl_wdata[4:0]] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Registered outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_rdata      <= 32'h00000000;
      ctrl_rvalid     <= 1'b0;
      reserved_insn   <= 1'b0;
      fp_exception    <= 1'b0;
      dest_write_en   <= 1'b0;
      nan_substitute  <= 1'b0;
      nan_payload     <= 6'h00;
      flush_subnormal <= `FLUSH_RESET;
      nontrap_mode    <= `NONTRAP_RESET;
      round_select    <= `ROUND_RESET;
      vreg_usable     <= 1'b0;
    end else begin
      ctrl_rvalid   <= rd_go;
      ctrl_rdata    <= rd_go ? rd_word : 32'h00000000;
      // Blocked access to index 2..7 is a reserved instruction
      reserved_insn <= (copy_to_control_insn | copy_from_control_insn) &
                       ~idx_ok;
      // Trap only in normal mode; or on software cause write
      fp_exception  <= (fp_insn_done && !nontrap_reg[fp_thread_sel] &&
                        trap_hit) || wr_trap;
      // Destination stays unwritten on a trap
      dest_write_en <= fp_insn_done &&
                       (nontrap_reg[fp_thread_sel] || !trap_hit);
      // Default results for untrapped cases are built by the datapath
      // from these controls
      nan_substitute <= fp_insn_done && nontrap_reg[fp_thread_sel] &&
                        trap_hit;
      nan_payload    <= cause_set;
      // Flush mode and rounding steer the datapath
      flush_subnormal <= flush_reg[fp_thread_sel];
      nontrap_mode    <= nontrap_reg[fp_thread_sel];
      round_select    <= round_reg[fp_thread_sel];
      // Without partitioning every vector register is usable
      vreg_usable <= !PARTITION_SUPPORT[0] ||
                     avail_reg[thread_sel][vreg_check];
    end
  end
endmodule
`default_nettype wire

// ===== test/vector_fp_regs_chk.sv
// Purpose: Port checks of the vector control register bank.
// Assumes: Answers come one cycle after the strobe edge.
// Notes:   Attached by the bind below the module.
`timescale 1ns/100ps
`default_nettype none
module vector_fp_regs_chk #(
  parameter       PARTITION_SUPPORT = 1'b1,
  parameter [7:0] PROCESSOR_CODE    = 8'h00,
  parameter [7:0] REVISION_CODE     = 8'h00
) (
  input wire        clk,
  input wire        reset_n,
  input wire        privileged_mode,
  input wire        copy_to_control_insn,
  input wire        copy_from_control_insn,
  input wire [2:0]  ctrl_index,
  input wire [31:0] ctrl_wdata,
  input wire        fp_insn_done,
  input wire [31:0] ctrl_rdata,
  input wire        ctrl_rvalid,
  input wire        reserved_insn,
  input wire        fp_exception,
  input wire        dest_write_en,
  input wire        nan_substitute
);
  localparam [31:0] IMPL = {15'h0000, PARTITION_SUPPORT ? 1'b1 : 1'b0,
                            PROCESSOR_CODE, REVISION_CODE};
  wire rd = copy_from_control_insn;
  wire wr = copy_to_control_insn;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rd_answer_a:
    assert property (rd && ctrl_index < 3'h2 |=> ctrl_rvalid)
    else $error("read got no answer");
  impl_value_a:
    assert property (rd && ctrl_index == 3'h0 |=> ctrl_rdata == IMPL)
    else $error("implementation value wrong");
  user_refuse_a:
    assert property ((rd || wr) && ctrl_index > 3'h1 && !privileged_mode
      |=> reserved_insn && !ctrl_rvalid) else $error("user access taken");
  csr_top_zero_a:
    assert property (rd && ctrl_index == 3'h1 |=> ctrl_rdata[31:25] == 7'h00)
    else $error("upper status bits not zero");
  sw_trap_a:
    assert property (wr && ctrl_index == 3'h1 && (ctrl_wdata[17] ||
      |(ctrl_wdata[16:12] & ctrl_wdata[11:7])) |=> fp_exception)
    else $error("written cause did not trap");
  trap_no_write_a:
    assert property (fp_exception |-> !dest_write_en)
    else $error("trap with destination write");
  nontrap_quiet_a:
    assert property (nan_substitute |-> !fp_exception)
    else $error("trap in non-trapping mode");
  rvalid_cause_a:
    assert property (ctrl_rvalid |-> $past(rd)) else $error("stray answer");
  no_cause_trap_a:
    assert property (!wr && !fp_insn_done |=> !fp_exception)
    else $error("trap without cause");
endmodule
bind vector_fp_control_regs vector_fp_regs_chk #(
  .PARTITION_SUPPORT(PARTITION_SUPPORT), .PROCESSOR_CODE(PROCESSOR_CODE),
  .REVISION_CODE(REVISION_CODE)
) chk (.clk, .reset_n, .privileged_mode, .copy_to_control_insn,
  .copy_from_control_insn, .ctrl_index, .ctrl_wdata, .fp_insn_done,
  .ctrl_rdata, .ctrl_rvalid, .reserved_insn, .fp_exception, .dest_write_en,
  .nan_substitute);
`default_nettype wire

// ===== test/fp_exec_model.sv
// Purpose: Execution unit that completes vector FP instructions.
// Assumes: Called at a falling edge; drives on falling edges.
// Notes:   Lane fields are six bits in cause order.
`timescale 1ns/100ps
`default_nettype none
module fp_exec_model (
  input  wire        clk,
  output logic       fp_insn_done,
  output logic [3:0] elem_valid,
  output logic [23:0] elem_exc,
  output logic [1:0] fp_thread_sel,
  output logic [31:0] modify_set
);
  initial begin
    {fp_insn_done, elem_valid, elem_exc} = 29'h0;
    {fp_thread_sel, modify_set} = 34'h0;
  end
  // Gap lets a caller model slow as well as prompt completion
  task issue(input [3:0] lanes, input [23:0] exc, input integer gap);
    begin
      repeat (gap + 1) @(negedge clk);
      fp_insn_done = 1'b1;
      elem_valid = lanes;
      elem_exc = exc;
      modify_set = {8'h00, exc};
      @(negedge clk);
      fp_insn_done = 1'b0;
      // Released lanes show junk, never the old value
      elem_valid = ~lanes;
      elem_exc = ~exc;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/vector_fp_control_regs_bench.sv
// Purpose: Self-checking bench of the vector control register bank.
// Assumes: Inputs move on the falling edge; one thread runs FP work.
// Notes:   Random status writes from a fixed seed plus corner cases.
`timescale 1ns/100ps
`default_nettype none
module vector_fp_control_regs_bench;
  localparam [31:0] IMPL = 32'h00015A01;
  logic        clk, reset_n, privileged_mode, request_load;
  logic        copy_to_control_insn, copy_from_control_insn;
  logic [1:0]  thread_sel;
  logic [2:0]  ctrl_index;
  logic [4:0]  vreg_check;
  logic [31:0] ctrl_wdata, request_bits, w;
  logic [31:0] csr [0:3];
  wire         fp_insn_done, ctrl_rvalid, reserved_insn, fp_exception;
  wire         dest_write_en, nan_substitute, flush_subnormal, vreg_usable;
  wire         nontrap_mode;
  wire [1:0]   fp_thread_sel, round_select;
  wire [3:0]   elem_valid;
  wire [5:0]   nan_payload;
  wire [23:0]  elem_exc;
  wire [31:0]  modify_set, ctrl_rdata;
  integer      err_count, tests_run, seed, i;
  integer      cycles = 0;
  vector_fp_control_regs uut (.clk, .reset_n, .thread_sel, .privileged_mode,
    .copy_to_control_insn, .copy_from_control_insn, .ctrl_index, .ctrl_wdata,
    .fp_insn_done, .elem_valid, .elem_exc, .fp_thread_sel, .modify_set,
    .request_bits, .request_load, .vreg_check, .ctrl_rdata, .ctrl_rvalid,
    .reserved_insn, .fp_exception, .dest_write_en, .nan_substitute,
    .nan_payload, .flush_subnormal, .nontrap_mode, .round_select,
    .vreg_usable);
  fp_exec_model px (.clk, .fp_insn_done, .elem_valid, .elem_exc,
    .fp_thread_sel, .modify_set);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reserved status bits read back as zero
  function [31:0] csr_view(input [31:0] v);
    csr_view = v & 32'h0107FFFF;
  endfunction
  task check(input [39:0] got, input [39:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Idle edge first, so strobes never drop and rise in one step
  task acc(input wr, input [2:0] idx, input [31:0] d);
    begin
      @(negedge clk);
      copy_to_control_insn = wr;
      copy_from_control_insn = !wr;
      ctrl_index = idx;
      ctrl_wdata = d;
      @(negedge clk);
      copy_to_control_insn = 1'b0;
      copy_from_control_insn = 1'b0;
      ctrl_wdata = ~d;
    end
  endtask
  task end_sim;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  initial begin
    seed = 32'h0418;
    err_count = 0;
    tests_run = 0;
    {reset_n, privileged_mode, request_load, thread_sel} = 5'h00;
    {copy_to_control_insn, copy_from_control_insn, ctrl_index} = 5'h00;
    {vreg_check, ctrl_wdata, request_bits} = 69'h0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check({flush_subnormal, nontrap_mode, round_select}, 0);
    acc(0, 3'h0, 0);
    check({ctrl_rvalid, ctrl_rdata}, {1'b1, IMPL});
    privileged_mode = 1'b1;
    acc(0, 3'h2, 0);
    check(ctrl_rdata, 0);
    for (i = 0; i < 12; i = i + 1) begin
      w = $random(seed);
      privileged_mode = w[31];
      w = w & 32'h01FFFFFF;
      thread_sel = i[1:0];
      csr[i % 4] = csr_view(w);
      acc(1, 3'h1, w);
      check(fp_exception, w[17] | (|(w[16:12] & w[11:7])));
      acc(0, 3'h1, 0);
      check(ctrl_rdata, csr[i % 4]);
      if (i % 4 == 0) begin
        check({flush_subnormal, nontrap_mode, round_select},
              {w[24], w[18], w[1:0]});
      end
    end
    for (i = 0; i < 4; i = i + 1) begin
      thread_sel = i[1:0];
      acc(0, 3'h1, 0);
      check(ctrl_rdata, csr[i]);
    end
    privileged_mode = 1'b0;
    for (i = 2; i < 8; i = i + 1) begin
      acc(i[0], i[2:0], $random(seed));
      check({reserved_insn, ctrl_rvalid}, 2'h2);
    end
    thread_sel = 2'h0;
    acc(1, 3'h1, 0);
    px.issue(4'h4, 24'h404000, 0);
    check({dest_write_en, fp_exception}, 2'h2);
    acc(0, 3'h1, 0);
    check(ctrl_rdata, 32'h00005014);
    px.issue(4'hF, 24'h000000, 3);
    acc(0, 3'h1, 0);
    check(ctrl_rdata, 32'h00000014);
    acc(1, 3'h1, 32'h00000200);
    px.issue(4'h1, 24'h000004, 1);
    check({dest_write_en, fp_exception}, 2'h1);
    acc(0, 3'h1, 0);
    check(ctrl_rdata[6:2], 0);
    acc(1, 3'h1, 0);
    px.issue(4'h1, 24'h000020, 1);
    check(fp_exception, 1);
    // Invalid enabled, so nontrap mode substitutes instead of trapping
    acc(1, 3'h1, 32'h00040800);
    px.issue(4'h3, 24'h000400, 1);
    check({nan_substitute, fp_exception, nan_payload}, 8'h90);
    acc(0, 3'h1, 0);
    check(ctrl_rdata, 32'h00040800);
    privileged_mode = 1'b1;
    vreg_check = 5'h05;
    acc(1, 3'h6, 32'h00000005);
    acc(0, 3'h2, 0);
    check({vreg_usable, ctrl_rdata}, 33'h100000020);
    acc(0, 3'h4, 0);
    check(ctrl_rdata, 32'h00404424);
    acc(1, 3'h7, 32'h00000005);
    acc(0, 3'h2, 0);
    check({vreg_usable, ctrl_rdata}, 0);
    end_sim;
  end
endmodule
`default_nettype wire
